// ### pkg/vectored_irq_ctrl_pkg.sv
/*
 * Constants shared by the vectored interrupt controller: sizes, the
 * register map seen over AHB-Lite, field positions and values after reset.
 * Assumes a 32-bit AHB-Lite bus carrying word-sized single transfers only.
 */
package vectored_irq_ctrl_pkg;

    localparam int NUM_INPUTS = 56;
    localparam int PRIO_W = 4;
    localparam int IDX_W = 6;
    localparam int NUM_TARGETS = 2;
    localparam int OFS_W = 12;

    // Target numbers as held in the per-input target field
    localparam logic TARGET_FAST = 1'b0;
    localparam logic TARGET_STD = 1'b1;

    // Register byte offsets
    localparam logic [OFS_W-1:0] THR_FAST_OFS = 12'h000;
    localparam logic [OFS_W-1:0] THR_STD_OFS = 12'h004;
    localparam logic [OFS_W-1:0] VEC_FAST_OFS = 12'h010;
    localparam logic [OFS_W-1:0] VEC_STD_OFS = 12'h014;
    localparam logic [OFS_W-1:0] RAW_LO_OFS = 12'h020;
    localparam logic [OFS_W-1:0] RAW_HI_OFS = 12'h024;
    localparam logic [OFS_W-1:0] CFG_BASE_OFS = 12'h100;
    localparam logic [OFS_W-1:0] CFG_LAST_OFS = 12'h1dc;

    // Per-input configuration word fields
    localparam int CFG_PRIO_LSB = 0;
    localparam int CFG_TARGET_BIT = 8;
    localparam int CFG_POL_BIT = 16;
    localparam int CFG_SWREQ_BIT = 24;
    localparam int CFG_PIN_BIT = 30;
    localparam int CFG_REQ_BIT = 31;

    // Vector word fields
    localparam int VEC_IDX_LSB = 0;
    localparam int VEC_PRIO_LSB = 8;
    localparam int VEC_VALID_BIT = 31;

    // Values after reset
    localparam logic [PRIO_W-1:0] PRIO_RST = 4'h0;
    localparam logic [PRIO_W-1:0] THR_RST = 4'h0;
    localparam logic TARGET_RST = 1'b1;
    localparam logic POL_RST = 1'b0;
    localparam logic SWREQ_RST = 1'b0;

    // AHB-Lite encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'b0;

endpackage

// ### src/vectored_priority_irq_router.sv
/*
 * Vectored interrupt controller: 56 level request inputs, each with its own
 * polarity, software request, priority and target, routed to a fast and a
 * standard processor interrupt line with a vector per line.
 * Assumes a single AHB-Lite master, word transfers only, and request inputs
 * that may come from other clock domains (they are synchronised here).
 */
// Decided for this implementation: the address map and the AHB-Lite slave port.
// Functional notes
// - There are 56 level request inputs, each with a software-chosen active level (high or low).
// - Each input has a software request bit that raises the interrupt with no peripheral activity.
// - Software can read the state of every request before any priority masking.
// - Each input has a software-programmable target choosing the processor line it drives.
// - Target 0 is the fast interrupt line and target 1 is the standard interrupt line.
// - Masking is per target, comparing each routed request's priority with that target's threshold.
// - A request with priority 0 is masked and never interrupts any target.
// - Nonzero priorities rank from 1 as the lowest up to 15 as the highest.
// - Each input has a writable priority field covering 15 active levels.
// - Each target has a vector that names the requesting input without a scan.
// - A higher-priority request can interrupt while a lower one is still in service.
// - All logic, registers and request sampling run on the controller's own clock.
// - The controller is held in reset by the warm reset.
`timescale 1ns/100ps
`default_nettype none

module vectored_priority_irq_router (
    input wire logic core_clk_in,
    input wire logic rst_b_in,
    input wire logic [vectored_irq_ctrl_pkg::NUM_INPUTS-1:0] irq_req_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    output logic fast_interrupt_line_out,
    output logic std_interrupt_line_out
);

    localparam int N = vectored_irq_ctrl_pkg::NUM_INPUTS;
    localparam int PW = vectored_irq_ctrl_pkg::PRIO_W;
    localparam int IW = vectored_irq_ctrl_pkg::IDX_W;
    localparam int OW = vectored_irq_ctrl_pkg::OFS_W;

    typedef struct packed {
        logic [N-1:0] sync1;
        logic [N-1:0] sync2;
        logic [N-1:0][PW-1:0] prio;
        logic [N-1:0] target;
        logic [N-1:0] pol;
        logic [N-1:0] swreq;
        logic [1:0][PW-1:0] thr;
        logic [1:0][31:0] vec;
        logic [1:0] line;
        logic ph_valid;
        logic ph_write;
        logic [OW-1:0] ph_addr;
        logic rd_pending;
        logic hreadyout;
        logic hresp;
        logic [31:0] hrdata;
    } ctrl_state_t;

    ctrl_state_t state_reg;
    ctrl_state_t state_next;
    logic [N-1:0] req;

    // Request state before masking: synchronised pin, level flipped by
    // polarity, or-ed with the software request.
    genvar gi;
    generate
        for (gi = 0; gi < N; gi++) begin : g_req
            assign req[gi] = (state_reg.sync2[gi] ^ state_reg.pol[gi]) | state_reg.swreq[gi];
        end
    endgenerate

    // Byte offset to configuration slot; used by both read and write paths
    function automatic logic [IW:0] cfg_slot(input logic [OW-1:0] ofs);
        logic [OW-1:0] rel;
        rel = ofs - vectored_irq_ctrl_pkg::CFG_BASE_OFS;
        if (ofs >= vectored_irq_ctrl_pkg::CFG_BASE_OFS && ofs <= vectored_irq_ctrl_pkg::CFG_LAST_OFS &&
            ofs[1:0] == 2'h0) begin
            cfg_slot = {1'b1, rel[IW+1:2]};
        end else begin
            cfg_slot = {1'b0, {IW{1'b0}}};
        end
    endfunction

    function automatic logic [31:0] read_word(input ctrl_state_t s, input logic [N-1:0] r,
                                              input logic [OW-1:0] ofs);
        logic [IW:0] slot;
        logic [31:0] w;
        slot = cfg_slot(ofs);
        w = 32'h0000_0000;
        if (ofs == vectored_irq_ctrl_pkg::THR_FAST_OFS) begin
            w[PW-1:0] = s.thr[vectored_irq_ctrl_pkg::TARGET_FAST];
        end else if (ofs == vectored_irq_ctrl_pkg::THR_STD_OFS) begin
            w[PW-1:0] = s.thr[vectored_irq_ctrl_pkg::TARGET_STD];
        end else if (ofs == vectored_irq_ctrl_pkg::VEC_FAST_OFS) begin
            w = s.vec[vectored_irq_ctrl_pkg::TARGET_FAST];
        end else if (ofs == vectored_irq_ctrl_pkg::VEC_STD_OFS) begin
            w = s.vec[vectored_irq_ctrl_pkg::TARGET_STD];
        end else if (ofs == vectored_irq_ctrl_pkg::RAW_LO_OFS) begin
            w = r[31:0];
        end else if (ofs == vectored_irq_ctrl_pkg::RAW_HI_OFS) begin
            w[N-33:0] = r[N-1:32];
        end else if (slot[IW]) begin
            w[vectored_irq_ctrl_pkg::CFG_PRIO_LSB +: PW] = s.prio[slot[IW-1:0]];
            w[vectored_irq_ctrl_pkg::CFG_TARGET_BIT] = s.target[slot[IW-1:0]];
            w[vectored_irq_ctrl_pkg::CFG_POL_BIT] = s.pol[slot[IW-1:0]];
            w[vectored_irq_ctrl_pkg::CFG_SWREQ_BIT] = s.swreq[slot[IW-1:0]];
            w[vectored_irq_ctrl_pkg::CFG_PIN_BIT] = s.sync2[slot[IW-1:0]];
            w[vectored_irq_ctrl_pkg::CFG_REQ_BIT] = r[slot[IW-1:0]];
        end
        read_word = w;
    endfunction

    always_comb begin
        logic [PW-1:0] best_prio;
        logic [IW-1:0] best_idx;
        logic [IW:0] wslot;
        logic accept;
        best_prio = '0;
        best_idx = '0;
        wslot = '0;
        accept = 1'b0;
        state_next = state_reg;

        // Two-stage synchroniser; only stage two feeds logic
        state_next.sync1 = irq_req_in;
        state_next.sync2 = state_reg.sync1;

        // Per-target arbitration. Strict greater-than keeps the lowest index
        // on a tie and never lets priority 0 win, since best starts at 0.
        for (int t = 0; t < vectored_irq_ctrl_pkg::NUM_TARGETS; t++) begin
            best_prio = '0;
            best_idx = '0;
            for (int i = 0; i < N; i++) begin
                if (req[i] && state_reg.target[i] == t[0] && state_reg.prio[i] > best_prio) begin
                    best_prio = state_reg.prio[i];
                    best_idx = IW'(i);
                end
            end
            // Threshold masking; software nests by raising the threshold to
            // the priority in service, so only higher levels break through.
            state_next.line[t] = best_prio > state_reg.thr[t];
            state_next.vec[t] = 32'h0000_0000;
            state_next.vec[t][vectored_irq_ctrl_pkg::VEC_IDX_LSB +: IW] = best_idx;
            state_next.vec[t][vectored_irq_ctrl_pkg::VEC_PRIO_LSB +: PW] = best_prio;
            state_next.vec[t][vectored_irq_ctrl_pkg::VEC_VALID_BIT] = best_prio > state_reg.thr[t];
        end

        // Write data phase: hwdata belongs to the address captured last cycle
        if (state_reg.ph_valid && state_reg.ph_write) begin
            wslot = cfg_slot(state_reg.ph_addr);
            if (state_reg.ph_addr == vectored_irq_ctrl_pkg::THR_FAST_OFS) begin
                state_next.thr[vectored_irq_ctrl_pkg::TARGET_FAST] = hwdata_in[PW-1:0];
            end else if (state_reg.ph_addr == vectored_irq_ctrl_pkg::THR_STD_OFS) begin
                state_next.thr[vectored_irq_ctrl_pkg::TARGET_STD] = hwdata_in[PW-1:0];
            end else if (wslot[IW]) begin
                state_next.prio[wslot[IW-1:0]] = hwdata_in[vectored_irq_ctrl_pkg::CFG_PRIO_LSB +: PW];
                state_next.target[wslot[IW-1:0]] = hwdata_in[vectored_irq_ctrl_pkg::CFG_TARGET_BIT];
                state_next.pol[wslot[IW-1:0]] = hwdata_in[vectored_irq_ctrl_pkg::CFG_POL_BIT];
                state_next.swreq[wslot[IW-1:0]] = hwdata_in[vectored_irq_ctrl_pkg::CFG_SWREQ_BIT];
            end
        end

        // Reads take one wait state so a write just before is already visible
        if (state_reg.rd_pending) begin
            state_next.hrdata = read_word(state_reg, req, state_reg.ph_addr);
            state_next.rd_pending = 1'b0;
            state_next.hreadyout = 1'b1;
        end

        accept = hsel_in && hready_in && htrans_in == vectored_irq_ctrl_pkg::HTRANS_NONSEQ;
        state_next.ph_valid = accept;
        if (accept) begin
            state_next.ph_write = hwrite_in;
            state_next.ph_addr = haddr_in[OW-1:0];
            if (!hwrite_in) begin
                state_next.rd_pending = 1'b1;
                state_next.hreadyout = 1'b0;
            end
        end
        state_next.hresp = vectored_irq_ctrl_pkg::HRESP_OKAY;
    end

    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_reg.sync1 <= '0;
            state_reg.sync2 <= '0;
            state_reg.prio <= {N{vectored_irq_ctrl_pkg::PRIO_RST}};
            state_reg.target <= {N{vectored_irq_ctrl_pkg::TARGET_RST}};
            state_reg.pol <= {N{vectored_irq_ctrl_pkg::POL_RST}};
            state_reg.swreq <= {N{vectored_irq_ctrl_pkg::SWREQ_RST}};
            state_reg.thr <= {2{vectored_irq_ctrl_pkg::THR_RST}};
            state_reg.vec <= '0;
            state_reg.line <= '0;
            state_reg.ph_valid <= 1'b0;
            state_reg.ph_write <= 1'b0;
            state_reg.ph_addr <= '0;
            state_reg.rd_pending <= 1'b0;
            state_reg.hreadyout <= 1'b1;
            state_reg.hresp <= vectored_irq_ctrl_pkg::HRESP_OKAY;
            state_reg.hrdata <= 32'h0000_0000;
        end else begin
            state_reg <= state_next;
        end
    end

    assign hrdata_out = state_reg.hrdata;
    assign hreadyout_out = state_reg.hreadyout;
    assign hresp_out = state_reg.hresp;
    assign fast_interrupt_line_out = state_reg.line[vectored_irq_ctrl_pkg::TARGET_FAST];
    assign std_interrupt_line_out = state_reg.line[vectored_irq_ctrl_pkg::TARGET_STD];

endmodule

`default_nettype wire

// ### testbench/vpir_props.sv
/* Port checker for the interrupt router.
   Assumes one AHB-Lite master with hready_in tied to hreadyout_out. */
`timescale 1ns/100ps
`default_nettype none
module vpir_props (
    input wire logic core_clk_in,
    input wire logic rst_b_in,
    input wire logic [55:0] irq_req_in,
    input wire logic hsel_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic hready_in,
    input wire logic [31:0] hrdata_out,
    input wire logic hreadyout_out,
    input wire logic hresp_out,
    input wire logic fast_interrupt_line_out,
    input wire logic std_interrupt_line_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!rst_b_in);
    logic taken;
    logic rd_d_reg;
    logic [55:0] req_prev_reg;
    logic [2:0] quiet_reg;
    assign taken = hsel_in && hready_in && htrans_in == vectored_irq_ctrl_pkg::HTRANS_NONSEQ;
    // Cycles since the last thing that may move a line; it saturates
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rd_d_reg <= 1'b0;
            req_prev_reg <= '0;
            quiet_reg <= '0;
        end else begin
            rd_d_reg <= taken && !hwrite_in;
            req_prev_reg <= irq_req_in;
            if (irq_req_in != req_prev_reg || (taken && hwrite_in)) begin
                quiet_reg <= 3'h0;
            end else if (quiet_reg != 3'h7) begin
                quiet_reg <= quiet_reg + 3'h1;
            end
        end
    end
    property p_rst_lines;
        $rose(rst_b_in) |-> !fast_interrupt_line_out && !std_interrupt_line_out;
    endproperty
    a_rst_lines: assert property (p_rst_lines) else $error("line high after reset");
    property p_okay;
        hresp_out == vectored_irq_ctrl_pkg::HRESP_OKAY;
    endproperty
    a_okay: assert property (p_okay) else $error("response not okay");
    property p_read_wait;
        taken && !hwrite_in |=> !hreadyout_out ##1 hreadyout_out;
    endproperty
    a_read_wait: assert property (p_read_wait) else $error("read wait state wrong");
    property p_ready_cause;
        !hreadyout_out |-> rd_d_reg;
    endproperty
    a_ready_cause: assert property (p_ready_cause) else $error("stray wait state");
    property p_write_nowait;
        taken && hwrite_in |=> hreadyout_out;
    endproperty
    a_write_nowait: assert property (p_write_nowait) else $error("write stalled");
    property p_rdata_hold;
        $changed(hrdata_out) |-> $past(rd_d_reg);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
    property p_fast_cause;
        $changed(fast_interrupt_line_out) |-> quiet_reg < 3'h5;
    endproperty
    a_fast_cause: assert property (p_fast_cause) else $error("fast line moved alone");
    property p_std_cause;
        $changed(std_interrupt_line_out) |-> quiet_reg < 3'h5;
    endproperty
    a_std_cause: assert property (p_std_cause) else $error("std line moved alone");
endmodule
`default_nettype wire

// ### testbench/irq_core_model.sv
/* Processor model: counts handler entries on each interrupt line.
   Assumes active-high level lines; the core has no acknowledge path back. */
`timescale 1ns/100ps
`default_nettype none
module irq_core_model (
    input wire logic core_clk_in,
    input wire logic rst_b_in,
    input wire logic fast_line_in,
    input wire logic std_line_in,
    output logic [7:0] fast_entry_cnt_out,
    output logic [7:0] std_entry_cnt_out
);
    logic fast_prev_reg;
    logic std_prev_reg;
    // A rising level is one handler entry; software then masks via threshold
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            fast_prev_reg <= 1'b0;
            std_prev_reg <= 1'b0;
            fast_entry_cnt_out <= '0;
            std_entry_cnt_out <= '0;
        end else begin
            fast_prev_reg <= fast_line_in;
            std_prev_reg <= std_line_in;
            fast_entry_cnt_out <= fast_entry_cnt_out + 8'(fast_line_in && !fast_prev_reg);
            std_entry_cnt_out <= std_entry_cnt_out + 8'(std_line_in && !std_prev_reg);
        end
    end
endmodule
`default_nettype wire

// ### testbench/tb_vectored_priority_irq_router.sv
/* Self-checking bench for the interrupt router, AHB-Lite master and checks.
   Assumes the package and design are compiled before this file. */
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin error_cnt++; \
    $display("Error %s exp %h got %h", n, e, s); end end
module tb_vectored_priority_irq_router;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [55:0] irq_req = '0;
    logic hsel = 1'b0;
    logic [31:0] haddr = '0;
    logic [1:0] htrans = '0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = '0;
    logic [31:0] hrdata;
    logic hready;
    logic hresp;
    logic fast;
    logic stdl;
    logic [7:0] fast_cnt;
    logic [7:0] std_cnt;
    logic rd_dp = 1'b0;
    logic [31:0] exp_v;
    logic [31:0] exp_q[$];
    logic [63:0] rnd;
    int seed;
    int error_cnt = 0;
    int cmp_count = 0;
    vectored_priority_irq_router dut (.core_clk_in(core_clk), .rst_b_in(rst_b), .irq_req_in(irq_req),
        .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
        .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready),
        .hresp_out(hresp), .fast_interrupt_line_out(fast), .std_interrupt_line_out(stdl));
    irq_core_model core (.core_clk_in(core_clk), .rst_b_in(rst_b), .fast_line_in(fast),
        .std_line_in(stdl), .fast_entry_cnt_out(fast_cnt), .std_entry_cnt_out(std_cnt));
    initial begin
        forever #5 core_clk = ~core_clk;
    end
    task automatic stop_test();
        $display("Compares %0d, errors %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // hready is polled at the falling edge so the value is settled
    task automatic wait_rdy();
        int n;
        n = 0;
        @(negedge core_clk);
        while (hready !== 1'b1) begin
            n++;
            if (n > 20) begin
                error_cnt++;
                stop_test();
            end
            @(negedge core_clk);
        end
    endtask
    task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {20'h0, a};
        hwrite <= w;
        htrans <= vectored_irq_ctrl_pkg::HTRANS_NONSEQ;
        wait_rdy();
        @(posedge core_clk);
        htrans <= 2'h0;
        hwdata <= d;
        rd_dp <= !w;
        wait_rdy();
        @(posedge core_clk);
        rd_dp <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(a, 1'b0, 32'h0);
    endtask
    task automatic lines(input logic f, input logic s);
        repeat (2) @(negedge core_clk);
        `CHK("fast line", f, fast)
        `CHK("std line", s, stdl)
        @(posedge core_clk);
    endtask
    function automatic logic [11:0] cfg(input int i);
        return vectored_irq_ctrl_pkg::CFG_BASE_OFS + 12'(4 * i);
    endfunction
    always @(negedge core_clk) begin
        if (rd_dp && hready === 1'b1) begin
            exp_v = exp_q.size() > 0 ? exp_q.pop_front() : 32'hdead_beef;
            `CHK("read data", exp_v, hrdata)
        end
    end
    initial begin
        seed = 32'h7c28;
        repeat (8) @(posedge core_clk);
        rst_b <= 1'b1;
        @(posedge core_clk);
        rd(vectored_irq_ctrl_pkg::THR_FAST_OFS, 32'h0);
        rd(cfg(5), 32'h0000_0100);
        rd(12'h800, 32'h0);
        rnd = {$random(seed), $random(seed)};
        irq_req <= rnd[55:0];
        repeat (4) @(posedge core_clk);
        rd(vectored_irq_ctrl_pkg::RAW_LO_OFS, rnd[31:0]);
        rd(vectored_irq_ctrl_pkg::RAW_HI_OFS, {8'h0, rnd[55:32]});
        bus(cfg(3), 1'b1, 32'h0001_0100);
        rd(vectored_irq_ctrl_pkg::RAW_LO_OFS, rnd[31:0] ^ 32'h8);
        lines(1'b0, 1'b0);
        irq_req <= '0;
        repeat (4) @(posedge core_clk);
        rd(cfg(3), 32'h8001_0100);
        bus(cfg(40), 1'b1, 32'h0100_0005);
        rd(vectored_irq_ctrl_pkg::RAW_HI_OFS, 32'h0000_0100);
        lines(1'b1, 1'b0);
        rd(vectored_irq_ctrl_pkg::VEC_FAST_OFS, 32'h8000_0528);
        bus(vectored_irq_ctrl_pkg::THR_FAST_OFS, 1'b1, 32'h5);
        lines(1'b0, 1'b0);
        rd(vectored_irq_ctrl_pkg::VEC_FAST_OFS, 32'h0000_0528);
        bus(vectored_irq_ctrl_pkg::THR_FAST_OFS, 1'b1, 32'h4);
        lines(1'b1, 1'b0);
        bus(cfg(40), 1'b1, 32'h0100_0000);
        lines(1'b0, 1'b0);
        bus(cfg(20), 1'b1, 32'h0100_0103);
        lines(1'b0, 1'b1);
        rd(vectored_irq_ctrl_pkg::VEC_STD_OFS, 32'h8000_0314);
        bus(vectored_irq_ctrl_pkg::THR_STD_OFS, 1'b1, 32'h3);
        lines(1'b0, 1'b0);
        bus(cfg(10), 1'b1, 32'h0100_010f);
        lines(1'b0, 1'b1);
        bus(cfg(7), 1'b1, 32'h0100_010f);
        rd(vectored_irq_ctrl_pkg::VEC_STD_OFS, 32'h8000_0f07);
        `CHK("fast entries", 8'd2, fast_cnt)
        `CHK("std entries", 8'd2, std_cnt)
        // A pin, not a software request, drives the fast line here
        bus(cfg(50), 1'b1, 32'h0000_0009);
        lines(1'b0, 1'b1);
        irq_req <= 56'h04_0000_0000_0000;
        repeat (4) @(posedge core_clk);
        lines(1'b1, 1'b1);
        rd(vectored_irq_ctrl_pkg::VEC_FAST_OFS, 32'h8000_0932);
        rd(cfg(50), 32'hc000_0009);
        irq_req <= '0;
        repeat (4) @(posedge core_clk);
        lines(1'b0, 1'b1);
        bus(cfg(50), 1'b1, 32'h0001_0009);
        lines(1'b1, 1'b1);
        // Warm reset in mid-run must drop the lines and the configuration
        rst_b <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_b <= 1'b1;
        @(posedge core_clk);
        lines(1'b0, 1'b0);
        rd(cfg(50), 32'h0000_0100);
        rd(vectored_irq_ctrl_pkg::THR_STD_OFS, 32'h0);
        stop_test();
    end
endmodule
bind vectored_priority_irq_router vpir_props chk (.core_clk_in, .rst_b_in, .irq_req_in, .hsel_in,
    .htrans_in, .hwrite_in, .hready_in, .hrdata_out, .hreadyout_out, .hresp_out,
    .fast_interrupt_line_out, .std_interrupt_line_out);
`default_nettype wire
